// file: hw/dcap_map.svh
// Functional notes
// RQ1 - Won but stopped: hold D, keep address
// RQ2 - Device makes stop/go flag in channel 2
// RQ3 - Skip arbitration two frames after each frame
// RQ4 - Signalling uses class 1, others class 2
// RQ5 - Lower level after success, restored later
// RQ6 - Idle station sends continuous ones on D
// RQ7 - Over seven ones means channel idle
// RQ8 - Thresholds 8/10 normal, 9/11 lower level
// RQ9 - Echo ones counted, zero restarts count
// RQ10 - Collision: stop, monitor again, send ones
// RQ11 - Terminal multipoint: mode field 001 or 011
// RQ12 - Device compares D with echo continuously; code compares echo only on address bits while arbitrating
// RQ13 - Activation code 1000b/1001b selects class
// RQ14 - After activated indication send class request
// RQ15 - Device accepts class change while activated
// RQ16 - Trunk terminal resets to transparent D
// RQ17 - Trunk multipoint: mode field 001 or 011
// RQ18 - Network termination arbitrates local sources
// RQ19 - Layer 1 channel 1, traffic on 0
// RQ20 - Layer 2 uses slot zero, reads both
// RQ21 - Priority handler enabled, 8 or 10
// RQ22 - Arbitrate only while access flag is one
// RQ23 - Zeros win; overridden station drives ones
// RQ24 - Network handler: n ones before proceed
// RQ25 - Ones counter saturates, clears on zero
// RQ26 - Default class 8 until request chosen
`ifndef DCAP_MAP_SVH
`define DCAP_MAP_SVH
// ----------------------------------------
// Bit positions within a bus frame, and the bit counter step
// ----------------------------------------
`define DCAP_POS_D0      8'h18
`define DCAP_POS_D1      8'h19
`define DCAP_POS_CI0     8'h1A
`define DCAP_POS_CI3     8'h1D
`define DCAP_POS_BAC     8'h58
`define DCAP_POS_TBA0    8'h59
`define DCAP_POS_TBA2    8'h5B
`define DCAP_POS_SG      8'h5C
`define DCAP_CNT_ONE     8'h01
// ----------------------------------------
// Codes and counts
// ----------------------------------------
`define DCAP_HOLD_FRAMES 2'h2
`define DCAP_HOLD_ONE    2'h1
`define DCAP_CI_AR8      4'h8
`define DCAP_CI_ACTIVATE_REQUEST_LOW_PRIO     4'h9
`define DCAP_CI_AI       4'hC
`define DCAP_CI_DI       4'hF
`define DCAP_MODE_COLL   3'h1
`define DCAP_MODE_TRANSP 3'h0
`define DCAP_L1_CHAN     3'h1
`define DCAP_MAP_CHAN    3'h0
`define DCAP_SYNC_W      4
// Pin idle levels: data lines high, clock and sync low
`define DCAP_SYNC_IDLE   4'hC
`endif

// file: hw/dcap_pkg.sv
package dcap_pkg;
   typedef enum logic [2:0] {
      DCAP_IDLE,
      DCAP_ARB,
      DCAP_SEND,
      DCAP_HOLD
   } dcap_state_e;

   typedef struct packed {
      logic [3:0] q1;
      logic [3:0] q2;
      logic [3:0] q3;
      logic [3:0] lvl;
      logic [3:0] rise;
      logic [3:0] fall;
   } dcap_sync_s;

   typedef struct packed {
      dcap_state_e st;
      logic [7:0]  bit_cnt;
      logic        fs_pend;
      logic        drive_low;
      logic        lost;
      logic        sg_stop;
      logic        started;
      logic [1:0]  hold_cnt;
      logic [3:0]  ci_tx;
      logic [3:0]  ci_rx;
      logic        activated;
      logic        done;
      logic        abort;
   } dcap_ctrl_s;
endpackage

// file: hw/dcap_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dcap_sync_if;
   logic [3:0] raw;
   logic [3:0] lvl;
   logic [3:0] rise;
   logic [3:0] fall;
   modport sync (input raw, output lvl, output rise, output fall);
   modport user (output raw, input lvl, input rise, input fall);
endinterface
`default_nettype wire

// file: hw/dcap_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcap_map.svh"
module dcap_sync
   import dcap_pkg::*;
(
   // Clock and reset
   input  wire logic  sys_clk,
   input  wire logic  rst_b,
   // Pin side
   dcap_sync_if.sync  sif
);
   dcap_sync_s s;
   dcap_sync_s next_s;

   // ----------------------------------------
   // Three stages, change taken when 2 and 3 agree
   // ----------------------------------------
   always_comb begin
      next_s      = s;
      next_s.q1   = sif.raw;
      next_s.q2   = s.q1;
      next_s.q3   = s.q2;
      for (int i = 0; i < `DCAP_SYNC_W; i++) begin
         if (s.q2[i] == s.q3[i]) begin
            next_s.lvl[i] = s.q3[i];
         end
      end
      next_s.rise = next_s.lvl & ~s.lvl;
      next_s.fall = ~next_s.lvl & s.lvl;
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '{q1: `DCAP_SYNC_IDLE, q2: `DCAP_SYNC_IDLE, q3: `DCAP_SYNC_IDLE,
                lvl: `DCAP_SYNC_IDLE, rise: 4'h0, fall: 4'h0};
      end else begin
         s <= next_s;
      end
   end

   assign sif.lvl  = s.lvl;
   assign sif.rise = s.rise;
   assign sif.fall = s.fall;
endmodule
`default_nettype wire

// file: hw/dcap_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcap_map.svh"
module dcap_ctrl
   import dcap_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   // Terminal bus pins
   input  wire logic       bus_data_clock,
   input  wire logic       frame_sync,
   input  wire logic       data_down,
   input  wire logic       data_up_in,
   output logic            data_up_out,
   output logic            data_up_oe,
   // Transmit stream
   input  wire logic [2:0] arbitration_address_bits,
   input  wire logic       tx_valid,
   input  wire logic       tx_bit,
   input  wire logic       tx_last,
   output logic            tx_ready,
   output logic            tx_done,
   output logic            tx_abort,
   // Activation and class
   input  wire logic       act_req,
   input  wire logic       prio_signalling,
   output logic            activated,
   // Configuration
   input  wire logic       coll_enable,
   input  wire logic       inet_mode,
   output logic [2:0]      dchan_mode_field,
   output logic [2:0]      l1_chan_sel,
   output logic            nt_fsm_on,
   output logic [2:0]      map_chan_sel
);
   dcap_ctrl_s s;
   dcap_ctrl_s next_s;
   dcap_sync_if sif ();
   logic       dcl_re;
   logic       dcl_fe;
   logic       fs_re;
   logic       dn_v;
   logic       up_v;
   logic [7:0] cnt_n;
   logic       d_pos;
   logic [3:0] class_code;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   assign sif.raw = {data_up_in, data_down, frame_sync, bus_data_clock};

   dcap_sync u_sync (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .sif     (sif)
   );

   assign dcl_re = sif.rise[0];
   assign dcl_fe = sif.fall[0];
   assign fs_re  = sif.rise[1];
   assign dn_v   = sif.lvl[2];
   assign up_v   = sif.lvl[3];
   assign cnt_n  = s.fs_pend ? 8'h00 : s.bit_cnt + `DCAP_CNT_ONE;
   assign d_pos  = (cnt_n == `DCAP_POS_D0) || (cnt_n == `DCAP_POS_D1);
   assign class_code = prio_signalling ? `DCAP_CI_AR8 : `DCAP_CI_ACTIVATE_REQUEST_LOW_PRIO; // RQ4 RQ26

   // Data bit consumed only on go
   assign tx_ready = dcl_re && d_pos && (s.st == DCAP_SEND) && !s.sg_stop; // RQ1

   // ----------------------------------------
   // Frame timing, arbitration and transmit
   // ----------------------------------------
   always_comb begin
      next_s      = s;
      next_s.done  = 1'b0;
      next_s.abort = 1'b0;
      next_s.ci_tx = (act_req || s.activated) ? class_code : `DCAP_CI_DI; // RQ14
      if (fs_re) begin
         next_s.fs_pend = 1'b1;
         if (s.st == DCAP_HOLD) begin
            if (s.hold_cnt <= `DCAP_HOLD_ONE) begin
               next_s.st = DCAP_IDLE;
            end
            next_s.hold_cnt = s.hold_cnt - `DCAP_HOLD_ONE; // RQ3
         end
      end
      if (dcl_re) begin
         next_s.fs_pend   = 1'b0;
         next_s.bit_cnt   = cnt_n;
         next_s.drive_low = 1'b0; // RQ6
         if (d_pos) begin
            if (tx_ready && tx_valid) begin
               next_s.drive_low = !tx_bit;
               next_s.started   = 1'b1;
               if (tx_last) begin
                  next_s.done     = 1'b1;
                  next_s.st       = DCAP_HOLD;
                  next_s.hold_cnt = `DCAP_HOLD_FRAMES; // RQ3
               end
            end
         end else if (cnt_n >= `DCAP_POS_CI0 && cnt_n <= `DCAP_POS_CI3) begin
            next_s.drive_low = !s.ci_tx[3 - 2'(cnt_n - `DCAP_POS_CI0)]; // RQ20
         end else if (cnt_n == `DCAP_POS_BAC) begin
            next_s.drive_low = (s.st == DCAP_SEND); // RQ1
         end else if (cnt_n >= `DCAP_POS_TBA0 && cnt_n <= `DCAP_POS_TBA2) begin
            if ((s.st == DCAP_ARB || s.st == DCAP_SEND) && !s.lost) begin
               next_s.drive_low =
                  !arbitration_address_bits[2'(cnt_n - `DCAP_POS_TBA0)]; // RQ23
            end
         end
      end
      if (dcl_fe) begin
         if (s.bit_cnt == `DCAP_POS_BAC) begin
            if (s.st == DCAP_IDLE && tx_valid && up_v) begin
               next_s.st   = DCAP_ARB; // RQ22
               next_s.lost = 1'b0;
            end
         end
         if (s.st == DCAP_ARB && s.bit_cnt >= `DCAP_POS_TBA0
             && s.bit_cnt <= `DCAP_POS_TBA2) begin
            if (arbitration_address_bits[2'(s.bit_cnt - `DCAP_POS_TBA0)] != up_v) begin
               next_s.lost = 1'b1; // RQ23
            end
            if (s.bit_cnt == `DCAP_POS_TBA2) begin
               next_s.st      = next_s.lost ? DCAP_IDLE : DCAP_SEND;
               next_s.started = 1'b0;
            end
         end
         if (s.bit_cnt == `DCAP_POS_SG) begin
            next_s.sg_stop = dn_v;
            if (s.st == DCAP_SEND && s.started && dn_v) begin
               next_s.st    = DCAP_IDLE; // RQ10
               next_s.abort = 1'b1;
            end
         end
         if (s.bit_cnt >= `DCAP_POS_CI0 && s.bit_cnt <= `DCAP_POS_CI3) begin
            next_s.ci_rx = {s.ci_rx[2:0], dn_v};
            if (s.bit_cnt == `DCAP_POS_CI3) begin
               if ({s.ci_rx[2:0], dn_v} == `DCAP_CI_AI) begin
                  next_s.activated = 1'b1; // RQ14
               end else if ({s.ci_rx[2:0], dn_v} == `DCAP_CI_DI) begin
                  next_s.activated = 1'b0;
               end
            end
         end
      end
      case (next_s.st)
         DCAP_IDLE, DCAP_ARB, DCAP_SEND, DCAP_HOLD: begin
         end
         default: begin
            next_s.st = DCAP_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '{st: DCAP_IDLE, bit_cnt: 8'h00, fs_pend: 1'b0, drive_low: 1'b0,
                lost: 1'b0, sg_stop: 1'b1, started: 1'b0, hold_cnt: 2'h0,
                ci_tx: `DCAP_CI_DI, ci_rx: `DCAP_CI_DI, activated: 1'b0,
                done: 1'b0, abort: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign data_up_out      = 1'b0;
   assign data_up_oe       = s.drive_low;
   assign tx_done          = s.done;
   assign tx_abort         = s.abort;
   assign activated        = s.activated;
   assign dchan_mode_field = coll_enable ? `DCAP_MODE_COLL : `DCAP_MODE_TRANSP; // RQ11 RQ17
   assign l1_chan_sel      = inet_mode ? `DCAP_L1_CHAN : `DCAP_MAP_CHAN; // RQ19
   assign nt_fsm_on        = inet_mode; // RQ19
   assign map_chan_sel     = `DCAP_MAP_CHAN; // RQ19

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   chk_idle_dbits: assert property ( // RQ6
      ($past(s.st) != DCAP_SEND && $changed(s.bit_cnt)
       && (s.bit_cnt == `DCAP_POS_D0 || s.bit_cnt == `DCAP_POS_D1))
      |-> !s.drive_low) else $error("D bit driven outside send");
   chk_hold_len: assert property ( // RQ3
      $rose(s.st == DCAP_HOLD) |-> s.hold_cnt == `DCAP_HOLD_FRAMES)
      else $error("hold-off not two frames");
   chk_hold_noarb: assert property ( // RQ3
      s.st == DCAP_HOLD |=> s.st != DCAP_ARB) else $error("arbitration during hold-off");
   chk_stop_holds: assert property ( // RQ1
      (s.st == DCAP_SEND && s.sg_stop) |-> !tx_ready) else $error("data taken on stop");
   chk_bac_kept: assert property ( // RQ1
      (s.st == DCAP_SEND && s.bit_cnt == `DCAP_POS_BAC && $changed(s.bit_cnt)
       && $past(s.st) == DCAP_SEND) |-> s.drive_low) else $error("access flag released");
   chk_arb_gate: assert property ( // RQ22
      $rose(s.st == DCAP_ARB) |-> $past(up_v) && $past(s.bit_cnt) == `DCAP_POS_BAC)
      else $error("arbitration without access flag");
   chk_withdraw: assert property ( // RQ23
      (s.st == DCAP_ARB && s.lost && $past(s.lost) && $changed(s.bit_cnt)
       && s.bit_cnt >= `DCAP_POS_TBA0 && s.bit_cnt <= `DCAP_POS_TBA2) |-> !s.drive_low)
      else $error("address driven after loss");
   chk_abort_stop: assert property ( // RQ10
      (s.st == DCAP_SEND && s.started && dcl_fe && s.bit_cnt == `DCAP_POS_SG && dn_v)
      |=> s.abort && s.st == DCAP_IDLE) else $error("no abort on collision");
   chk_class_code: assert property ( // RQ4
      (act_req && prio_signalling) ##1 (act_req && prio_signalling)
      |-> s.ci_tx == `DCAP_CI_AR8) else $error("wrong class request");
   chk_mode_field: assert property ( // RQ11
      coll_enable |-> dchan_mode_field == `DCAP_MODE_COLL) else $error("mode field wrong");

   cov_frame_sent: cover property (s.done);
   cov_collision: cover property (s.abort);
   cov_arb_lost: cover property ($rose(s.lost));
   cov_activated: cover property ($rose(s.activated));
endmodule
`default_nettype wire

// file: verification/dcap_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcap_dev_model (
   // Bus pins
   output logic       bus_data_clock,
   output logic       frame_sync,
   output logic       data_down,
   output logic       data_up_in,
   input  wire logic  data_up_out,
   input  wire logic  data_up_oe,
   // Bench control and view
   input  wire logic  force_stop,
   input  wire logic  deact,
   input  wire logic  rival_on,
   output logic [3:0] ci_up,
   output logic       cls10,
   output logic [7:0] d_log,
   output logic [7:0] act_hist,
   output logic       bac_now,
   output logic [2:0] adr_now,
   output logic       rival_won,
   output int         frames
);
   logic       sg, lower, arb, rival_oe, w;
   logic [3:0] ci_dn, cnt;
   int         b;
   // Open-drain wire with pull-up
   assign data_up_in = (data_up_oe ? data_up_out : 1'b1) & ~rival_oe;
   initial begin
      {bus_data_clock, frame_sync, lower, cls10, arb, rival_oe, rival_won} = '0;
      {data_down, sg, bac_now, ci_dn, ci_up, adr_now, d_log} = '1;
      {cnt, act_hist} = '0;
      frames = 0;
      b = 0;
      forever begin
         #30;
         frame_sync = (b == 0);
         rival_oe = (b == 88 && rival_won && rival_on) || (b > 88 && b < 92 && arb);
         data_down = (b > 25 && b < 30) ? ci_dn[29-b] : (b == 92) ? sg : 1'b1;
         #32.5 bus_data_clock = 1'b1;
         #60 w = data_up_in;
         if (b == 24 || b == 25) begin
            d_log = {d_log[6:0], w};
            cnt = !w ? 4'h0 : (cnt < 4'hB) ? cnt + 4'h1 : cnt;
         end
         if (b > 25 && b < 30) ci_up = {ci_up[2:0], w};
         if (b == 29 && (ci_up == 4'h8 || ci_up == 4'h9)) begin
            cls10 = ci_up[0];
            ci_dn = 4'hC;
         end
         if (b == 29 && deact) ci_dn = 4'hF;
         if (b == 88) begin
            lower = lower | (!bac_now && w && !sg);
            bac_now = w;
            arb = rival_on && w && !rival_won;
         end
         if (b > 88 && b < 92) adr_now[b-89] = w;
         if (b == 91) begin
            rival_won = rival_on && (rival_won || arb);
            if (force_stop) sg = 1'b1;
            else if (sg || bac_now) begin
               sg = cnt < (cls10 ? 4'hA : 4'h8) + {3'h0, lower};
               lower = lower & sg;
            end
         end
         if (b == 95) begin
            act_hist = {act_hist[6:0], !bac_now || adr_now != 3'b111};
            frames++;
         end
         #2.5 bus_data_clock = 1'b0;
         b = (b + 1) % 96;
      end
   end
endmodule
`default_nettype wire

// file: verification/dcap_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dcap_ctrl_tb;
   import dcap_pkg::*;
   logic       sys_clk, rst_b, bus_data_clock, frame_sync, data_down, data_up_in;
   logic       data_up_out, data_up_oe, tx_valid, tx_bit, tx_last, tx_ready, tx_done;
   logic       tx_abort, act_req, prio_signalling, activated, coll_enable, inet_mode;
   logic       nt_fsm_on, force_stop, deact, rival_on, cls10, bac_now, rival_won;
   logic [2:0] addr, dchan_mode_field, l1_chan_sel, map_chan_sel, adr_now;
   logic [3:0] ci_up;
   logic [7:0] d_log, act_hist;
   int         frames, fd, taken = 0, n_done = 0, n_abort = 0, cyc = 0;
   int         bad_count = 0, tests_run = 0;
   // ----------------------------------------
   // Design and device
   // ----------------------------------------
   dcap_ctrl u_dcap_ctrl (.sys_clk, .rst_b, .bus_data_clock, .frame_sync, .data_down,
      .data_up_in, .data_up_out, .data_up_oe, .arbitration_address_bits(addr), .tx_valid,
      .tx_bit, .tx_last, .tx_ready, .tx_done, .tx_abort, .act_req, .prio_signalling,
      .activated, .coll_enable, .inet_mode, .dchan_mode_field, .l1_chan_sel, .nt_fsm_on,
      .map_chan_sel);
   dcap_dev_model u_dcap_dev_model (.bus_data_clock, .frame_sync, .data_down, .data_up_in,
      .data_up_out, .data_up_oe, .force_stop, .deact, .rival_on, .ci_up, .cls10, .d_log,
      .act_hist, .bac_now, .adr_now, .rival_won, .frames);
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (tx_ready === 1'b1 && tx_valid === 1'b1) taken <= taken + 1;
      if (tx_done === 1'b1) n_done <= n_done + 1;
      if (tx_abort === 1'b1) n_abort <= n_abort + 1;
      if (cyc == 95000) begin
         bad_count++;
         report_and_stop;
      end
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_frames(input int n);
      int t;
      t = frames + n;
      while (frames < t) @(negedge sys_clk);
   endtask
   task automatic take_bit(input logic b, input logic last);
      {tx_valid, tx_bit, tx_last} = {1'b1, b, last};
      do @(posedge sys_clk); while (tx_ready !== 1'b1);
      @(negedge sys_clk);
   endtask
   task automatic report_and_stop;
      if (bad_count == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      {tx_valid, tx_bit, tx_last, act_req, coll_enable, inet_mode} = 6'b010000;
      {force_stop, deact, rival_on, rst_b, prio_signalling, addr} = 8'b00001010;
      repeat (5) @(negedge sys_clk);
      chk(16'({activated, tx_ready, data_up_oe, dchan_mode_field}), 16'h0000);
      {rst_b, coll_enable, inet_mode} = 3'b111;
      @(negedge sys_clk);
      chk(16'(dchan_mode_field), 16'h0001);
      chk(16'({l1_chan_sel, nt_fsm_on, map_chan_sel}), 16'h0018);
      act_req = 1'b1;
      wait_frames(3);
      chk(16'({ci_up, activated, d_log[1:0]}), 16'h0047);
      prio_signalling = 1'b0;
      wait_frames(2);
      chk(16'({ci_up, cls10}), 16'h0013);
      prio_signalling = 1'b1;
      wait_frames(2);
      chk(16'({ci_up, cls10}), 16'h0010);
      force_stop = 1'b1;
      {tx_valid, tx_bit} = 2'b10;
      wait_frames(3);
      chk({12'(taken), bac_now, adr_now}, 16'h0002);
      force_stop = 1'b0;
      take_bit(1'b0, 1'b0);
      take_bit(1'b1, 1'b0);
      take_bit(1'b1, 1'b0);
      take_bit(1'b0, 1'b1);
      {tx_bit, tx_last, fd} = {2'b10, frames};
      wait_frames(3);
      chk(16'(n_done), 16'h0001);
      chk(16'(d_log), 16'h006F);
      chk(16'(act_hist[2:0]), 16'h0001);
      take_bit(1'b0, 1'b0);
      chk(16'(frames - fd), 16'h0006);
      {force_stop, tx_bit} = 2'b11;
      while (n_abort == 0) @(negedge sys_clk);
      {tx_valid, force_stop} = 2'b00;
      wait_frames(2);
      chk({11'(taken), d_log[3:0], act_hist[0]}, 16'h00CE);
      {act_req, deact} = 2'b01;
      wait_frames(3);
      chk(16'({ci_up, activated}), 16'h001E);
      {deact, rival_on, tx_valid, tx_last} = 4'b0111;
      fd = taken;
      wait_frames(3);
      chk({14'(taken - fd), rival_won, bac_now}, 16'h0002);
      report_and_stop;
   end
endmodule
`default_nettype wire
